// ### ppo_pkg.sv
// Behaviour
// - sixteen outputs form four 4-bit groups that update together or independently
// - sixteen output data bits, each bit separately enabled for pulse output
// - each group picks its update trigger from four timer compare match inputs
// - non-overlap mode delays rising edges by a margin after falling edges
// - a group's selected compare match also raises a transfer request to the DMA side when the group has enabled bits
// - output pins can be driven inverted, chosen per group
// - after reset the block is halted; registers other than halt control reachable only once halt is cleared
// - enabled bit copies its next-value bit into output data on its group trigger
// - disabled bit is not copied on a trigger; its output holds
// - both enable registers clear to zero on reset
// - enabled output data bits ignore writes but read back; disabled bits accept writes
// - groups 3/2 share next-value high at one address, else split over two addresses
// - groups 1/0 share next-value low at one address, else split over two addresses
// - high enable bits gate pins 15..8, low enable bits gate pins 7..0
// - 2-bit select codes 00..11 pick timer channel 0..3; reset code is 11
package ppo_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_PORT1_DIR  = 16'hFEB0;
  localparam logic [15:0] IDX_PORT2_DIR  = 16'hFEB1;
  localparam logic [15:0] IDX_HALT_CTRL  = 16'hFF3C;
  localparam logic [15:0] IDX_TRIG_SEL   = 16'hFF46;
  localparam logic [15:0] IDX_MODE       = 16'hFF47;
  localparam logic [15:0] IDX_EN_HIGH    = 16'hFF48;
  localparam logic [15:0] IDX_EN_LOW     = 16'hFF49;
  localparam logic [15:0] IDX_OUT_HIGH   = 16'hFF4A;
  localparam logic [15:0] IDX_OUT_LOW    = 16'hFF4B;
  localparam logic [15:0] IDX_NEXT_HIGH  = 16'hFF4C;
  localparam logic [15:0] IDX_NEXT_LOW   = 16'hFF4D;
  localparam logic [15:0] IDX_NEXT_G2    = 16'hFF4E;
  localparam logic [15:0] IDX_NEXT_G0    = 16'hFF4F;
  // reset values
  localparam logic [7:0]  RST_DIR        = 8'h00;
  localparam logic [15:0] RST_HALT       = 16'h3FFF;
  localparam logic [7:0]  RST_TRIG_SEL   = 8'hFF;
  localparam logic [7:0]  RST_MODE       = 8'hF0;
  localparam logic [7:0]  RST_EN         = 8'h00;
  localparam logic [7:0]  RST_OUT        = 8'h00;
  localparam logic [7:0]  RST_NEXT       = 8'h00;
  localparam logic [7:0]  RESERVED_BYTE  = 8'hFF;
  localparam logic [3:0]  RESERVED_NIB   = 4'hF;
  // field positions
  localparam int HALT_BIT       = 11;
  localparam int MODE_DIRECT_LSB = 4;
  localparam int MODE_NONOVL_LSB = 0;
  // timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int MARGIN_NS      = 160;
  localparam int MARGIN_CYC_INT = (MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] MARGIN_CYC = 3'(MARGIN_CYC_INT < 1 ? 1 : MARGIN_CYC_INT);
endpackage : ppo_pkg

// ### ppo_top.sv
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
module ppo_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [3:0]  cmp_match,
  output logic      [3:0]  xfer_req,
  output logic      [15:0] pulse_pin,
  output logic      [15:0] pulse_pin_oe_n
);

  function automatic logic [1:0] grp_sel(input logic [7:0] sel, input int g);
    return sel[g*2 +: 2];
  endfunction : grp_sel

  logic [7:0]       port1_dir_q;
  logic [7:0]       port2_dir_q;
  logic [15:0]      halt_q;
  logic [7:0]       trig_sel_q;
  logic [7:0]       mode_q;
  logic [15:0]      en_q;
  logic [15:0]      pod_q;
  logic [15:0]      pod_d;
  logic [15:0]      nv_q;
  logic [3:0][3:0]  pend_q;
  logic [3:0][3:0]  pend_d;
  logic [3:0][2:0]  cnt_q;
  logic [3:0][2:0]  cnt_d;
  logic             wr_pend_q;
  logic             rd_pend_q;
  logic [15:0]      idx_q;
  logic [31:0]      hrdata_q;
  logic             hreadyout_q;
  logic             hresp_q;
  logic [3:0]       xfer_req_q;
  logic [15:0]      pin_q;
  logic [15:0]      oe_n_q;
  logic             run;
  logic             addr_ok;
  logic             wr_now;
  logic [3:0]       trig;
  logic             share_hi;
  logic             share_lo;
  logic [15:0]      inv_mask;
  logic [7:0]       rd_byte;

  assign hrdata         = hrdata_q;
  assign hreadyout      = hreadyout_q;
  assign hresp          = hresp_q;
  assign xfer_req       = xfer_req_q;
  assign pulse_pin      = pin_q;
  assign pulse_pin_oe_n = oe_n_q;

  assign run      = ~halt_q[ppo_pkg::HALT_BIT];
  assign addr_ok  = hsel & htrans[1] & hready & (haddr[31:18] == 14'h0000) & (haddr[1:0] == 2'h0);
  assign wr_now   = wr_pend_q & run;
  assign share_hi = grp_sel(trig_sel_q, 3) == grp_sel(trig_sel_q, 2);
  assign share_lo = grp_sel(trig_sel_q, 1) == grp_sel(trig_sel_q, 0);

  // group trigger is the selected channel's compare match, only while running
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      trig[g] = run & cmp_match[grp_sel(trig_sel_q, g)];
    end
  end

  // a clear direct bit means the group drives inverted data
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      inv_mask[g*4 +: 4] = {4{~mode_q[ppo_pkg::MODE_DIRECT_LSB + g]}};
    end
  end

  // bus phase tracking: writes have no wait state, reads take one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      idx_q       <= 16'h0000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      wr_pend_q   <= addr_ok & hwrite;
      rd_pend_q   <= addr_ok & ~hwrite;
      hreadyout_q <= ~(addr_ok & ~hwrite);
      hresp_q     <= 1'b0;
      if (addr_ok) begin
        idx_q <= haddr[17:2];
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (run) begin
      unique case (idx_q)
        ppo_pkg::IDX_TRIG_SEL:  rd_byte = trig_sel_q;
        ppo_pkg::IDX_MODE:      rd_byte = mode_q;
        ppo_pkg::IDX_EN_HIGH:   rd_byte = en_q[15:8];
        ppo_pkg::IDX_EN_LOW:    rd_byte = en_q[7:0];
        ppo_pkg::IDX_OUT_HIGH:  rd_byte = pod_q[15:8];
        ppo_pkg::IDX_OUT_LOW:   rd_byte = pod_q[7:0];
        ppo_pkg::IDX_NEXT_HIGH: rd_byte = share_hi ? nv_q[15:8] : {nv_q[15:12], ppo_pkg::RESERVED_NIB};
        ppo_pkg::IDX_NEXT_G2:   rd_byte = share_hi ? ppo_pkg::RESERVED_BYTE : {ppo_pkg::RESERVED_NIB, nv_q[11:8]};
        ppo_pkg::IDX_NEXT_LOW:  rd_byte = share_lo ? nv_q[7:0] : {nv_q[7:4], ppo_pkg::RESERVED_NIB};
        ppo_pkg::IDX_NEXT_G0:   rd_byte = share_lo ? ppo_pkg::RESERVED_BYTE : {ppo_pkg::RESERVED_NIB, nv_q[3:0]};
        default:                rd_byte = 8'h00;
      endcase
    end
  end

  // halt control is always reachable; other reads see zero while halted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      if (idx_q == ppo_pkg::IDX_HALT_CTRL) begin
        hrdata_q <= {16'h0000, halt_q};
      end else begin
        hrdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_q <= ppo_pkg::RST_HALT;
    end else if (wr_pend_q && idx_q == ppo_pkg::IDX_HALT_CTRL) begin
      halt_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port1_dir_q <= ppo_pkg::RST_DIR;
      port2_dir_q <= ppo_pkg::RST_DIR;
    end else if (wr_now) begin
      if (idx_q == ppo_pkg::IDX_PORT1_DIR) begin
        port1_dir_q <= hwdata[7:0];
      end
      if (idx_q == ppo_pkg::IDX_PORT2_DIR) begin
        port2_dir_q <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_sel_q <= ppo_pkg::RST_TRIG_SEL;
      mode_q     <= ppo_pkg::RST_MODE;
    end else if (wr_now) begin
      if (idx_q == ppo_pkg::IDX_TRIG_SEL) begin
        trig_sel_q <= hwdata[7:0];
      end
      if (idx_q == ppo_pkg::IDX_MODE) begin
        mode_q <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= {ppo_pkg::RST_EN, ppo_pkg::RST_EN};
    end else if (wr_now) begin
      if (idx_q == ppo_pkg::IDX_EN_HIGH) begin
        en_q[15:8] <= hwdata[7:0];
      end
      if (idx_q == ppo_pkg::IDX_EN_LOW) begin
        en_q[7:0] <= hwdata[7:0];
      end
    end
  end

  // next-value layout depends on whether paired groups share a trigger
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nv_q <= {ppo_pkg::RST_NEXT, ppo_pkg::RST_NEXT};
    end else if (wr_now) begin
      unique case (idx_q)
        ppo_pkg::IDX_NEXT_HIGH: begin
          nv_q[15:12] <= hwdata[7:4];
          if (share_hi) begin
            nv_q[11:8] <= hwdata[3:0];
          end
        end
        ppo_pkg::IDX_NEXT_G2: begin
          if (!share_hi) begin
            nv_q[11:8] <= hwdata[3:0];
          end
        end
        ppo_pkg::IDX_NEXT_LOW: begin
          nv_q[7:4] <= hwdata[7:4];
          if (share_lo) begin
            nv_q[3:0] <= hwdata[3:0];
          end
        end
        ppo_pkg::IDX_NEXT_G0: begin
          if (!share_lo) begin
            nv_q[3:0] <= hwdata[3:0];
          end
        end
        default: ;
      endcase
    end
  end

  // output data: cpu writes reach only disabled bits, triggers only enabled bits
  always_comb begin
    pod_d  = pod_q;
    pend_d = pend_q;
    cnt_d  = cnt_q;
    if (wr_now && idx_q == ppo_pkg::IDX_OUT_HIGH) begin
      pod_d[15:8] = (pod_q[15:8] & en_q[15:8]) | (hwdata[7:0] & ~en_q[15:8]);
    end
    if (wr_now && idx_q == ppo_pkg::IDX_OUT_LOW) begin
      pod_d[7:0] = (pod_q[7:0] & en_q[7:0]) | (hwdata[7:0] & ~en_q[7:0]);
    end
    for (int g = 0; g < 4; g++) begin
      if (cnt_q[g] != 3'h0) begin
        cnt_d[g] = cnt_q[g] - 3'h1;
        if (cnt_q[g] == 3'h1) begin
          pod_d[g*4 +: 4] = pod_d[g*4 +: 4] | pend_q[g];
          pend_d[g]       = 4'h0;
        end
      end
      if (trig[g]) begin
        if (mode_q[ppo_pkg::MODE_NONOVL_LSB + g]) begin
          // falling bits now, rising bits after the margin
          pod_d[g*4 +: 4] = pod_d[g*4 +: 4] & ~(en_q[g*4 +: 4] & ~nv_q[g*4 +: 4]);
          pend_d[g]       = en_q[g*4 +: 4] & nv_q[g*4 +: 4] & ~pod_d[g*4 +: 4];
          cnt_d[g]        = ppo_pkg::MARGIN_CYC;
        end else begin
          pod_d[g*4 +: 4] = (pod_d[g*4 +: 4] & ~en_q[g*4 +: 4])
                          | (nv_q[g*4 +: 4] & en_q[g*4 +: 4]);
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pod_q  <= {ppo_pkg::RST_OUT, ppo_pkg::RST_OUT};
      pend_q <= '0;
      cnt_q  <= '0;
    end else begin
      pod_q  <= pod_d;
      pend_q <= pend_d;
      cnt_q  <= cnt_d;
    end
  end

  // a channel raises a request when it triggers a group that has enabled bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_req_q <= 4'h0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        xfer_req_q[c] <= 1'b0;
        for (int g = 0; g < 4; g++) begin
          if (trig[g] && grp_sel(trig_sel_q, g) == 2'(c) && en_q[g*4 +: 4] != 4'h0) begin
            xfer_req_q[c] <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q  <= 16'h0000;
      oe_n_q <= 16'hFFFF;
    end else begin
      pin_q  <= pod_q ^ inv_mask;
      oe_n_q <= ~{port2_dir_q, port1_dir_q};
    end
  end

  next_copy_a : assert property (@(posedge hclk) disable iff (!hresetn)
    trig[0] && !mode_q[ppo_pkg::MODE_NONOVL_LSB] && cnt_q[0] == 3'h0
    && !(wr_now && idx_q == ppo_pkg::IDX_OUT_LOW)
    |=> pod_q[3:0] == (($past(nv_q[3:0]) & $past(en_q[3:0])) | ($past(pod_q[3:0]) & ~$past(en_q[3:0]))))
    else $error("enabled bits not transferred on trigger");

  hold_disabled_a : assert property (@(posedge hclk) disable iff (!hresetn)
    trig[1] && !(wr_now && idx_q == ppo_pkg::IDX_OUT_LOW) && cnt_q[1] == 3'h0
    |=> ((pod_q[7:4] ^ $past(pod_q[7:4])) & ~$past(en_q[7:4])) == 4'h0)
    else $error("disabled bits changed on trigger");

  halt_block_a : assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_q && !run
    |=> $stable(trig_sel_q) && $stable(mode_q) && $stable(en_q) && $stable(nv_q))
    else $error("write accepted while halted");

  ro_bits_a : assert property (@(posedge hclk) disable iff (!hresetn)
    wr_now && idx_q == ppo_pkg::IDX_OUT_LOW && trig[1:0] == 2'h0 && cnt_q[1:0] == '0
    |=> pod_q[7:0] == (($past(pod_q[7:0]) & $past(en_q[7:0])) | ($past(hwdata[7:0]) & ~$past(en_q[7:0]))))
    else $error("output data write masking wrong");

  pin_path_a : assert property (@(posedge hclk) disable iff (!hresetn)
    pin_q == ($past(pod_q) ^ $past(inv_mask)))
    else $error("pin does not follow output data");

  xfer_req_a : assert property (@(posedge hclk) disable iff (!hresetn)
    trig[2] && en_q[11:8] != 4'h0 |=> xfer_req_q[grp_sel($past(trig_sel_q), 2)])
    else $error("transfer request missing");

  nonovl_a : assert property (@(posedge hclk) disable iff (!hresetn)
    trig[0] && mode_q[ppo_pkg::MODE_NONOVL_LSB] && (en_q[3:0] & nv_q[3:0] & ~pod_q[3:0]) != 4'h0
    && !(wr_now && idx_q == ppo_pkg::IDX_OUT_LOW)
    |=> (pod_q[3:0] & pend_q[0]) == 4'h0 && cnt_q[0] == ppo_pkg::MARGIN_CYC)
    else $error("rising edge not delayed by margin");

  share_hi_a : assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_q && run && share_hi && idx_q == ppo_pkg::IDX_NEXT_G2 |=> hrdata_q[7:0] == 8'hFF && hreadyout_q)
    else $error("shared high alias not reading all ones");

  split_lo_a : assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_q && run && !share_lo && idx_q == ppo_pkg::IDX_NEXT_LOW |=> hrdata_q[3:0] == 4'hF)
    else $error("split low reserved nibble not ones");

  halted_read_a : assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_q && !run && idx_q != ppo_pkg::IDX_HALT_CTRL |=> hrdata_q == 32'h0000_0000)
    else $error("register readable while halted");

  en_map_a : assert property (@(posedge hclk) disable iff (!hresetn)
    wr_now && idx_q == ppo_pkg::IDX_EN_LOW |=> en_q[7:0] == $past(hwdata[7:0]))
    else $error("low enable write not stored in bit order");

  oe_follow_a : assert property (@(posedge hclk) disable iff (!hresetn)
    oe_n_q == ~{$past(port2_dir_q), $past(port1_dir_q)})
    else $error("pin enables do not follow direction");

  // covers for the main scenarios
  trig_cov_c    : cover property (@(posedge hclk) disable iff (!hresetn) trig[3] && en_q[15:12] != 4'h0);
  nonovl0_cov_c : cover property (@(posedge hclk) disable iff (!hresetn) cnt_q[0] == 3'h1 && pend_q[0] != 4'h0);
  nonovl_cov_c  : cover property (@(posedge hclk) disable iff (!hresetn) cnt_q[1] == 3'h1 && pend_q[1] != 4'h0);
  split_cov_c   : cover property (@(posedge hclk) disable iff (!hresetn) wr_now && !share_hi && idx_q == ppo_pkg::IDX_NEXT_G2);

endmodule : ppo_top

// ### ppo_timer_model.sv
`timescale 1ns/1ns
module ppo_timer_model (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic [3:0]      fire,
  input  wire logic            slow,
  input  wire logic [3:0]      xfer_req,
  output logic      [3:0]      cmp_match,
  output logic      [3:0][7:0] xfer_cnt
);
  logic [3:0] hold_q;
  // one compare match pulse per event; slow mode answers a cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_q    <= 4'h0;
      cmp_match <= 4'h0;
    end else begin
      hold_q    <= fire;
      cmp_match <= slow ? hold_q : fire;
    end
  end
  // transfer controller side counts requests per channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) xfer_cnt <= '0;
    else for (int i = 0; i < 4; i++) xfer_cnt[i] <= xfer_cnt[i] + 8'(xfer_req[i]);
  end
endmodule : ppo_timer_model

// ### pulse_pattern_output_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("Error %s expected %h seen %h", n, e, g); end end
module pulse_pattern_output_tb;
  logic            hclk, hresetn, hwrite, hreadyout, hresp, slow, pend;
  logic [1:0]      htrans;
  logic [31:0]     haddr, hwdata, hrdata, rnd, mon_e;
  logic [3:0]      fire, cmp_match, xfer_req;
  logic [15:0]     pulse_pin, pulse_pin_oe_n;
  logic [3:0][7:0] xfer_cnt;
  logic [7:0]      hi, lo;
  int              err_count, num_checks, cyc;
  string           mon_n;
  logic [31:0]     exp_q[$];
  string           nm_q[$];

  ppo_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cmp_match(cmp_match), .xfer_req(xfer_req), .pulse_pin(pulse_pin), .pulse_pin_oe_n(pulse_pin_oe_n));
  ppo_timer_model tmr_u (.hclk(hclk), .hresetn(hresetn), .fire(fire), .slow(slow), .xfer_req(xfer_req),
    .cmp_match(cmp_match), .xfer_cnt(xfer_cnt));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic addr_ph(input logic [15:0] idx, input logic w);
    @(posedge hclk);
    haddr  <= {14'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
  endtask : addr_ph

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    addr_ph(idx, 1'b1);
    hwdata <= {16'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : wr

  // expected read data is noted before the transfer starts
  task automatic rd(input logic [15:0] idx, input logic [31:0] e, input string n);
    exp_q.push_back(e);
    nm_q.push_back(n);
    addr_ph(idx, 1'b0);
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : rd

  task automatic trig(input int ch);
    @(posedge hclk);
    fire <= 4'(1 << ch);
    @(posedge hclk);
    fire <= 4'h0;
    repeat (8) @(posedge hclk);
  endtask : trig

  // read data monitor takes the oldest note when a read completes
  always @(posedge hclk) begin
    if (pend && hreadyout === 1'b1) begin
      mon_e = exp_q.pop_front();
      mon_n = nm_q.pop_front();
      `CHK(mon_n, mon_e, hrdata)
      `CHK("hresp", 1'b0, hresp)
      pend = 1'b0;
    end
    if (htrans[1] === 1'b1 && hwrite === 1'b0 && hreadyout === 1'b1) pend = 1'b1;
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    hresetn = 1'b0;
    htrans = 2'h0;
    haddr = '0;
    hwrite = 1'b0;
    hwdata = '0;
    fire = 4'h0;
    slow = 1'b0;
    pend = 1'b0;
    err_count = 0;
    num_checks = 0;
    cyc = 0;
    rnd = $urandom(66);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    `CHK("oe_n_rst", 16'hFFFF, pulse_pin_oe_n)
    wr(ppo_pkg::IDX_TRIG_SEL, 16'h0000);
    rd(ppo_pkg::IDX_TRIG_SEL, 32'h0, "trig_halted");
    wr(ppo_pkg::IDX_HALT_CTRL, 16'h37FF);
    rd(ppo_pkg::IDX_HALT_CTRL, 32'h37FF, "halt");
    rd(ppo_pkg::IDX_TRIG_SEL, 32'hFF, "trig_sel");
    rd(ppo_pkg::IDX_MODE, 32'hF0, "mode");
    rd(ppo_pkg::IDX_EN_HIGH, 32'h0, "en_hi");
    rd(ppo_pkg::IDX_EN_LOW, 32'h0, "en_lo");
    rd(ppo_pkg::IDX_PORT1_DIR, 32'h0, "dir_wo");
    rd(16'h0010, 32'h0, "unmapped");
    wr(ppo_pkg::IDX_PORT2_DIR, 16'h00FF);
    wr(ppo_pkg::IDX_PORT1_DIR, 16'h000F);
    wr(ppo_pkg::IDX_NEXT_HIGH, 16'h00A5);
    wr(ppo_pkg::IDX_NEXT_LOW, 16'h003C);
    wr(ppo_pkg::IDX_EN_HIGH, 16'h00F0);
    wr(ppo_pkg::IDX_EN_LOW, 16'h00FF);
    trig(3);
    `CHK("xfer_ch3", 8'h01, xfer_cnt[3])
    rd(ppo_pkg::IDX_OUT_HIGH, 32'hA0, "out_hi");
    rd(ppo_pkg::IDX_OUT_LOW, 32'h3C, "out_lo");
    wr(ppo_pkg::IDX_OUT_HIGH, 16'h00FF);
    rd(ppo_pkg::IDX_OUT_HIGH, 32'hAF, "out_hi_wr");
    @(posedge hclk);
    `CHK("pins", 16'hAF3C, pulse_pin)
    `CHK("oe_n", 16'h00F0, pulse_pin_oe_n)
    wr(ppo_pkg::IDX_MODE, 16'h00E0);
    repeat (2) @(posedge hclk);
    `CHK("pins_inv", 16'hAF33, pulse_pin)
    wr(ppo_pkg::IDX_EN_HIGH, 16'h00FF);
    hi = 8'hAF;
    lo = 8'h3C;
    for (int c = 0; c < 4; c++) begin
      rnd = $urandom();
      wr(ppo_pkg::IDX_TRIG_SEL, 16'(c * 85));
      wr(ppo_pkg::IDX_NEXT_HIGH, {8'h0, rnd[7:0]});
      wr(ppo_pkg::IDX_NEXT_LOW, {8'h0, rnd[15:8]});
      slow <= c[0];
      trig((c + 1) % 4);
      rd(ppo_pkg::IDX_OUT_HIGH, {24'h0, hi}, "no_trig");
      trig(c);
      hi = rnd[7:0];
      lo = rnd[15:8];
      rd(ppo_pkg::IDX_OUT_HIGH, {24'h0, hi}, "sel_hi");
      rd(ppo_pkg::IDX_OUT_LOW, {24'h0, lo}, "sel_lo");
    end
    `CHK("pins_rnd", {hi, lo ^ 8'h0F}, pulse_pin)
    wr(ppo_pkg::IDX_TRIG_SEL, 16'h001B);
    wr(ppo_pkg::IDX_NEXT_HIGH, 16'h005A);
    rd(ppo_pkg::IDX_NEXT_HIGH, 32'h5F, "nx_g3");
    wr(ppo_pkg::IDX_NEXT_G2, 16'h000C);
    rd(ppo_pkg::IDX_NEXT_G2, 32'hFC, "nx_g2");
    wr(ppo_pkg::IDX_NEXT_LOW, 16'h0096);
    rd(ppo_pkg::IDX_NEXT_LOW, 32'h9F, "nx_g1");
    wr(ppo_pkg::IDX_NEXT_G0, 16'h0003);
    rd(ppo_pkg::IDX_NEXT_G0, 32'hF3, "nx_g0");
    trig(1);
    rd(ppo_pkg::IDX_OUT_HIGH, {24'h0, hi[7:4], 4'hC}, "grp2_only");
    trig(3);
    rd(ppo_pkg::IDX_OUT_LOW, {24'h0, lo[7:4], 4'h3}, "grp0_only");
    // shared trigger, group 1 disabled, group 0 in non-overlap mode and inverted
    slow <= 1'b0;
    wr(ppo_pkg::IDX_TRIG_SEL, 16'h00FF);
    rd(ppo_pkg::IDX_NEXT_G2, 32'hFF, "nx_g2_rsv");
    wr(ppo_pkg::IDX_EN_LOW, 16'h000F);
    wr(ppo_pkg::IDX_OUT_LOW, 16'h00A5);
    rd(ppo_pkg::IDX_OUT_LOW, 32'hA3, "out_lo_wr");
    wr(ppo_pkg::IDX_MODE, 16'h00E1);
    wr(ppo_pkg::IDX_NEXT_LOW, 16'h00CC);
    @(posedge hclk);
    fire <= 4'h8;
    @(posedge hclk);
    fire <= 4'h0;
    repeat (6) @(posedge hclk);
    `CHK("nonovl_gap", 16'h5CAF, pulse_pin)
    @(posedge hclk);
    `CHK("nonovl_rise", 16'h5CA3, pulse_pin)
    rd(ppo_pkg::IDX_OUT_LOW, 32'hAC, "grp1_held");
    `CHK("xfer_ch3_all", 8'h04, xfer_cnt[3])
    report_and_stop();
  end
endmodule : pulse_pattern_output_tb
